// ### bench/sfe_host_model.sv
// Purpose: host serial controller model that drives the flash pins
// Assumes: 100 MHz core clock, 80 ns serial clock, mode 0, msb first
// Notes: after each frame the data line toggles for 8 cycles, so no stale bit looks valid
`timescale 1ns/1ns
module sfe_host_model (
    // clock
    input wire logic clock,
    // serial pins
    output logic sclk,
    output logic cs_b,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic dout;

    // ----------------------------------------------------------------------
    // level of the output wire as the host sees it
    // ----------------------------------------------------------------------
    // no pull on the wire: an undriven output reads as the inverse of its last value
    assign dout = serial_out_oe ? serial_out : ~serial_out;
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        serial_in = 1'b0;
    end

    // ----------------------------------------------------------------------
    // one framed transfer of n bits, left aligned in bits
    // ----------------------------------------------------------------------
    // rx gathers the output just before each falling edge, the value launched one fall earlier
    task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] rx);
        rx = 64'h0;
        @(posedge clock) cs_b <= 1'b0;
        repeat (3) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            rx = {rx[62:0], dout};
            sclk <= 1'b0;
            serial_in <= bits[63 - i];
            repeat (4) @(posedge clock);
            sclk <= 1'b1;
            repeat (3) @(posedge clock);
        end
        @(posedge clock);
        rx = {rx[62:0], dout};
        sclk <= 1'b0;
        repeat (4) @(posedge clock);
        cs_b <= 1'b1;
        repeat (8) @(posedge clock) serial_in <= ~serial_in;
    endtask : frame
endmodule : sfe_host_model

// ### bench/tb.sv
// Purpose: self-checking bench for the erase and deep sleep sequencer
// Assumes: host model owns the serial pins; erase counts shortened
// Notes: addresses, dummies and protect levels come from a fixed seed
`timescale 1ns/1ns
`include "sfe_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb;
    localparam logic [7:0] ID = 8'h3c; // arbitrary value
    logic clock, rst_b, sclk, cs_b, serial_in, serial_out, serial_out_oe;
    logic busy, latch, deep_sleep, erase_done, erase_all, oe_seen;
    logic [3:0] prot, lv;
    logic [7:0] erase_block;
    logic [31:0] st, a;
    logic [63:0] rx;
    int miscompares = 0;
    int num_checks = 0;

    // ----------------------------------------------------------------------
    // clock, design and host
    // ----------------------------------------------------------------------
    always #5 clock = ~clock;
    // sticky: did the device drive its output since last cleared
    always @(posedge clock) if (serial_out_oe) oe_seen <= 1'b1;
    sfe_flash_ctrl #(.BLOCK_ERASE_CYCLES(400), .ARRAY_ERASE_CYCLES(1000), .DEVICE_ID(ID)) DUT (
        .clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .protect_level_bits(prot),
        .write_in_progress_flag(busy), .write_unlock_latch(latch), .deep_sleep(deep_sleep),
        .erase_done(erase_done), .erase_all(erase_all), .erase_block(erase_block));
    sfe_host_model host (.clock(clock), .sclk(sclk), .cs_b(cs_b), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // ----------------------------------------------------------------------
    // expectations and helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : xs
    // level n in 1..8 covers the top 2^(n-1) blocks, above 8 covers all
    function automatic logic guarded(input logic [3:0] l, input logic [7:0] blk);
        if (l == 4'h0) return 1'b0;
        if (l > 4'h8) return 1'b1;
        return int'(blk) >= 256 - (1 << (int'(l) - 1));
    endfunction : guarded
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // bounded wait: 0 busy flag, 1 erase done, 2 deep sleep
    task automatic wait_on(input int sel, input logic v, input int lim);
        logic s;
        for (int i = 0; i <= lim; i++) begin
            @(posedge clock);
            s = (sel == 0) ? busy : (sel == 1) ? erase_done : deep_sleep;
            if (s === v) return;
        end
        miscompares++;
        $display("[FAIL] %0t wait %0h timed out", $time, sel);
        give_verdict();
    endtask : wait_on
    // unlock, one erase frame, then see it run to the end or see it dropped
    task automatic erase(input logic [63:0] b, input int n, input logic run,
                         input logic [7:0] blk);
        logic all;
        all = b[63:56] != `SFE_OP_BLOCK_ERASE;
        host.frame({`SFE_OP_WRITE_UNLOCK, 56'h0}, 8, rx);
        `CHK(latch, 1'b1)
        host.frame(b, n, rx);
        if (run) begin
            wait_on(0, 1'b1, 10);
            `CHK({latch, erase_all}, {1'b0, all})
            if (!all) `CHK(erase_block, blk)
            wait_on(1, 1'b1, 1100);
            `CHK(busy, 1'b0)
        end else begin
            repeat (20) @(posedge clock);
            `CHK({busy, latch}, 2'b01)
        end
    endtask : erase

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        prot = 4'h0;
        oe_seen = 1'b0;
        st = 32'd56;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK({busy, latch, deep_sleep}, 3'h0)
        a = xs();
        host.frame({`SFE_OP_WAKE_ID, a[23:0], 32'h0}, 48, rx);
        `CHK(rx[15:0], {ID, ID})
        host.frame({`SFE_OP_BLOCK_ERASE, a[23:0], 32'h0}, 32, rx);
        repeat (20) @(posedge clock);
        `CHK({busy, latch}, 2'b00)
        // random blocks and levels, then both sides of the level 1 edge
        for (int i = 0; i < 8; i++) begin
            a = xs();
            lv = (i >= 6) ? 4'h1 : a[27:24];
            if (i >= 6) a[23:16] = 8'(248 + i);
            prot <= lv;
            erase({`SFE_OP_BLOCK_ERASE, a[23:0], 32'h0}, 32, !guarded(lv, a[23:16]), a[23:16]);
        end
        prot <= 4'h0;
        erase({`SFE_OP_BLOCK_ERASE, a[23:0], 32'h0}, 31, 1'b0, 8'h0);
        erase({`SFE_OP_BLOCK_ERASE, a[23:0], 32'h0}, 33, 1'b0, 8'h0);
        erase({`SFE_OP_ARRAY_ERASE_A, 56'h0}, 9, 1'b0, 8'h0);
        erase({`SFE_OP_ARRAY_ERASE_B, 56'h0}, 8, 1'b1, 8'h0);
        prot <= a[3:0] | 4'h1;
        erase({`SFE_OP_ARRAY_ERASE_A, 56'h0}, 8, 1'b0, 8'h0);
        prot <= 4'h0;
        erase({`SFE_OP_ARRAY_ERASE_A, 56'h0}, 8, 1'b1, 8'h0);
        // sleep and identifier requests while an array erase runs
        host.frame({`SFE_OP_WRITE_UNLOCK, 56'h0}, 8, rx);
        host.frame({`SFE_OP_ARRAY_ERASE_B, 56'h0}, 8, rx);
        @(posedge clock) oe_seen <= 1'b0;
        host.frame({`SFE_OP_DEEP_SLEEP, 56'h0}, 8, rx);
        host.frame({`SFE_OP_WAKE_ID, a[23:0], 32'h0}, 48, rx);
        `CHK({busy, oe_seen}, 2'b10)
        wait_on(1, 1'b1, 1000);
        repeat (320) @(posedge clock);
        `CHK(deep_sleep, 1'b0)
        // sleep only after its delay; writes and erases unheard while asleep
        host.frame({`SFE_OP_DEEP_SLEEP, 56'h0}, 8, rx);
        `CHK(deep_sleep, 1'b0)
        wait_on(2, 1'b1, `SFE_SLEEP_ENTRY_CYC);
        host.frame({`SFE_OP_WRITE_UNLOCK, 56'h0}, 8, rx);
        host.frame({`SFE_OP_BLOCK_ERASE, a[23:0], 32'h0}, 32, rx);
        repeat (20) @(posedge clock);
        `CHK({busy, latch, deep_sleep}, 3'b001)
        @(posedge clock) oe_seen <= 1'b0;
        host.frame({`SFE_OP_WAKE_ID, a[23:0], 32'h0}, 48, rx);
        `CHK({deep_sleep, oe_seen}, 2'b00)
        host.frame({`SFE_OP_WRITE_UNLOCK, 56'h0}, 8, rx);
        `CHK(latch, 1'b0)
        repeat (200) @(posedge clock);
        host.frame({`SFE_OP_WRITE_UNLOCK, 56'h0}, 8, rx);
        `CHK(latch, 1'b1)
        // plain wake: a frame started inside the recovery time is ignored, the next one gets the id
        host.frame({`SFE_OP_DEEP_SLEEP, 56'h0}, 8, rx);
        wait_on(2, 1'b1, `SFE_SLEEP_ENTRY_CYC);
        host.frame({`SFE_OP_WAKE_ID, 56'h0}, 8, rx);
        `CHK(deep_sleep, 1'b0)
        @(posedge clock) oe_seen <= 1'b0;
        host.frame({`SFE_OP_WAKE_ID, a[23:0], 32'h0}, 48, rx);
        `CHK(oe_seen, 1'b0)
        host.frame({`SFE_OP_WAKE_ID, a[23:0], 32'h0}, 48, rx);
        `CHK(rx[15:0], {ID, ID})
        // reset while asleep must land in standby with the latch clear
        host.frame({`SFE_OP_DEEP_SLEEP, 56'h0}, 8, rx);
        wait_on(2, 1'b1, `SFE_SLEEP_ENTRY_CYC);
        `CHK({latch, deep_sleep}, 2'h3)
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK({busy, latch, deep_sleep}, 3'h0)
        give_verdict();
    end
endmodule : tb

// ### rtl/sfe_flash_ctrl.sv
// Purpose: instruction sequencer for erase, deep sleep and wake with id
// Assumes: serial clock and chip select come from the host, sampled here
// Notes: the array itself is outside; erase_done with block/all names it
`timescale 1ns/1ns
`include "sfe_map.svh"
module sfe_flash_ctrl #(
    parameter longint unsigned BLOCK_ERASE_CYCLES =
        64'(`SFE_BLOCK_ERASE_TIME_MS) * 64'(`SFE_CYC_PER_MS),
    parameter longint unsigned ARRAY_ERASE_CYCLES =
        64'(`SFE_ARRAY_ERASE_TIME_MS) * 64'(`SFE_CYC_PER_MS),
    parameter logic [7:0] DEVICE_ID = 8'h5a // arbitrary value
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // serial pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // configuration
    input wire logic [3:0] protect_level_bits,
    // status
    output logic write_in_progress_flag,
    output logic write_unlock_latch,
    output logic deep_sleep,
    // array erase command
    output logic erase_done,
    output logic erase_all,
    output logic [7:0] erase_block
);
    localparam int CW = $clog2(ARRAY_ERASE_CYCLES + 64'h1);
    localparam int WW = `SFE_WAIT_W;

    // refuse counts the timer cannot hold; busy must stand at least two cycles
    if (BLOCK_ERASE_CYCLES < 64'h2 || ARRAY_ERASE_CYCLES < BLOCK_ERASE_CYCLES) begin : g_chk
        $error("erase cycle counts out of range");
    end

    // ------------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------------
    // level 0 none, 9 and above all, else the top 2^(level-1) blocks
    function automatic logic block_is_protected(input logic [7:0] blk, input logic [3:0] lvl);
        logic [8:0] first;
        first = 9'h000;
        if (lvl == `SFE_PROTECT_NONE) begin
            return 1'b0;
        end else if (lvl >= 4'h9) begin
            return 1'b1;
        end
        first = 9'h100 - (9'h001 << (lvl - 4'h1));
        return {1'b0, blk} >= first;
    endfunction : block_is_protected

    sfe_link_if link ();

    sfe_pin_sync u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .sclk_pin(sclk),
        .cs_b_pin(cs_b),
        .serial_in_pin(serial_in),
        .link(link)
    );

    logic [5:0] bit_cnt_q, bit_cnt_d;
    logic [31:0] shift_q, shift_d;
    logic [7:0] opcode_q, opcode_d;
    logic frame_ok_q, frame_ok_d;
    logic id_on_q, id_on_d;
    logic [2:0] id_idx_q, id_idx_d;
    logic sout_q, sout_d;
    logic oe_q, oe_d;
    logic wel_q, wel_d;
    logic wip_q, wip_d;
    sfe_pkg::sfe_erase_t ers_q, ers_d;
    logic [CW-1:0] ers_cnt_q, ers_cnt_d;
    logic [7:0] blk_q, blk_d;
    logic all_q, all_d;
    logic done_q, done_d;
    sfe_pkg::sfe_pwr_t pwr_q, pwr_d;
    logic [WW-1:0] wait_q, wait_d;
    logic sleep_q, sleep_d;
    logic awake;
    logic op_ok;
    logic start_block;
    logic start_array;

    // ------------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------------
    // only a frame that ends exactly after its last bit is executed, except a wake, which may run longer
    always_comb begin
        awake = pwr_q == sfe_pkg::PWR_STANDBY;
        op_ok = link.cs_rise && frame_ok_q;
        start_block = op_ok && awake && bit_cnt_q == `SFE_ADDR_END_BITS
            && opcode_q == `SFE_OP_BLOCK_ERASE && wel_q
            && !block_is_protected(shift_q[`SFE_BLOCK_MSB:`SFE_BLOCK_LSB],
                                   protect_level_bits);
        start_array = op_ok && awake && bit_cnt_q == `SFE_OPCODE_BITS && wel_q
            && (opcode_q == `SFE_OP_ARRAY_ERASE_A || opcode_q == `SFE_OP_ARRAY_ERASE_B)
            && protect_level_bits == `SFE_PROTECT_NONE;
    end

    // ------------------------------------------------------------------
    // serial shifter and identifier output
    // ------------------------------------------------------------------
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        opcode_d = opcode_q;
        frame_ok_d = frame_ok_q;
        id_on_d = id_on_q;
        id_idx_d = id_idx_q;
        sout_d = sout_q;
        oe_d = oe_q;
        if (link.cs_fall) begin
            bit_cnt_d = 6'h00;
            // frames during an erase or a wake delay are not decoded
            frame_ok_d = ers_q == sfe_pkg::ERS_IDLE && pwr_q != sfe_pkg::PWR_WAKING;
        end else if (link.sclk_rise && link.cs_low) begin
            shift_d = {shift_q[30:0], link.data_bit};
            if (bit_cnt_q != `SFE_BIT_CNT_MAX) begin
                bit_cnt_d = bit_cnt_q + 6'h01;
            end
            if (bit_cnt_q == `SFE_OPCODE_BITS - 6'h01) begin
                opcode_d = {shift_q[6:0], link.data_bit};
            end
            // three dummy bytes done: stream the id, awake only
            if (bit_cnt_q == `SFE_ADDR_END_BITS - 6'h01 && frame_ok_q && awake
                && opcode_q == `SFE_OP_WAKE_ID) begin
                id_on_d = 1'b1;
                id_idx_d = `SFE_ID_MSB_IDX;
            end
        end else if (link.sclk_fall && id_on_q && link.cs_low) begin
            // msb first, wraps to repeat the byte
            sout_d = DEVICE_ID[id_idx_q];
            id_idx_d = id_idx_q - 3'h1;
            oe_d = 1'b1;
        end
        if (link.cs_rise || !link.cs_low) begin
            id_on_d = 1'b0;
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
            opcode_q <= 8'h00;
            frame_ok_q <= 1'b0;
            id_on_q <= 1'b0;
            id_idx_q <= 3'h7;
            sout_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            opcode_q <= opcode_d;
            frame_ok_q <= frame_ok_d;
            id_on_q <= id_on_d;
            id_idx_q <= id_idx_d;
            sout_q <= sout_d;
            oe_q <= oe_d;
        end
    end

    // ------------------------------------------------------------------
    // unlock latch, erase cycle and power state
    // ------------------------------------------------------------------
    // one timer per cycle kind; erase and power waits never overlap
    always_comb begin
        wel_d = wel_q;
        ers_d = ers_q;
        ers_cnt_d = ers_cnt_q;
        blk_d = blk_q;
        all_d = all_q;
        done_d = 1'b0;
        pwr_d = pwr_q;
        wait_d = wait_q;
        if (op_ok && awake && bit_cnt_q == `SFE_OPCODE_BITS
            && opcode_q == `SFE_OP_WRITE_UNLOCK) begin
            wel_d = 1'b1;
        end
        if (start_block || start_array) begin
            // latch drops at start, well before the cycle ends
            wel_d = 1'b0;
            ers_d = start_block ? sfe_pkg::ERS_BLOCK : sfe_pkg::ERS_ARRAY;
            ers_cnt_d = start_block ? CW'(BLOCK_ERASE_CYCLES - 64'h1)
                                    : CW'(ARRAY_ERASE_CYCLES - 64'h1);
            blk_d = shift_q[`SFE_BLOCK_MSB:`SFE_BLOCK_LSB];
            all_d = start_array;
        end else if (ers_q != sfe_pkg::ERS_IDLE) begin
            if (ers_cnt_q == '0) begin
                ers_d = sfe_pkg::ERS_IDLE;
                done_d = 1'b1;
            end else begin
                ers_cnt_d = ers_cnt_q - CW'(1);
            end
        end
        unique case (pwr_q)
            sfe_pkg::PWR_STANDBY: begin
                if (op_ok && bit_cnt_q == `SFE_OPCODE_BITS
                    && opcode_q == `SFE_OP_DEEP_SLEEP) begin
                    pwr_d = sfe_pkg::PWR_ENTERING;
                    wait_d = WW'(`SFE_SLEEP_ENTRY_CYC - 1);
                end
            end
            sfe_pkg::PWR_ENTERING, sfe_pkg::PWR_ASLEEP: begin
                // only the wake opcode is heard here
                if (op_ok && bit_cnt_q >= `SFE_OPCODE_BITS
                    && opcode_q == `SFE_OP_WAKE_ID) begin
                    pwr_d = sfe_pkg::PWR_WAKING;
                    wait_d = (bit_cnt_q == `SFE_OPCODE_BITS) ? WW'(`SFE_WAKE_PLAIN_CYC - 1)
                                                             : WW'(`SFE_WAKE_WITH_ID_CYC - 1);
                end else if (pwr_q == sfe_pkg::PWR_ENTERING) begin
                    if (wait_q == '0) begin
                        pwr_d = sfe_pkg::PWR_ASLEEP;
                    end else begin
                        wait_d = wait_q - WW'(1);
                    end
                end
            end
            sfe_pkg::PWR_WAKING: begin
                if (wait_q == '0) begin
                    pwr_d = sfe_pkg::PWR_STANDBY;
                end else begin
                    wait_d = wait_q - WW'(1);
                end
            end
        endcase
        wip_d = ers_d != sfe_pkg::ERS_IDLE;
        sleep_d = pwr_d == sfe_pkg::PWR_ASLEEP;
    end

    // reset always lands in standby with no cycle running
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wel_q <= 1'b0;
            wip_q <= 1'b0;
            ers_q <= sfe_pkg::ERS_IDLE;
            ers_cnt_q <= '0;
            blk_q <= 8'h00;
            all_q <= 1'b0;
            done_q <= 1'b0;
            pwr_q <= sfe_pkg::PWR_STANDBY;
            wait_q <= '0;
            sleep_q <= 1'b0;
        end else begin
            wel_q <= wel_d;
            wip_q <= wip_d;
            ers_q <= ers_d;
            ers_cnt_q <= ers_cnt_d;
            blk_q <= blk_d;
            all_q <= all_d;
            done_q <= done_d;
            pwr_q <= pwr_d;
            wait_q <= wait_d;
            sleep_q <= sleep_d;
        end
    end

    // outputs straight from flops
    assign serial_out = sout_q;
    assign serial_out_oe = oe_q;
    assign write_in_progress_flag = wip_q;
    assign write_unlock_latch = wel_q;
    assign deep_sleep = sleep_q;
    assign erase_done = done_q;
    assign erase_all = all_q;
    assign erase_block = blk_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_done_ends_busy;
        @(posedge clock) disable iff (!rst_b) done_q |-> $fell(wip_q);
    endproperty
    a_done_ends_busy: assert property (p_done_ends_busy) else $error("erase done without busy end");

    property p_block_needs_unlock;
        @(posedge clock) disable iff (!rst_b) start_block |-> wel_q && !wip_q;
    endproperty
    a_block_needs_unlock: assert property (p_block_needs_unlock) else $error("erase without unlock");

    property p_block_exact_frame;
        @(posedge clock) disable iff (!rst_b)
            start_block |-> bit_cnt_q == `SFE_ADDR_END_BITS && link.cs_rise;
    endproperty
    a_block_exact_frame: assert property (p_block_exact_frame) else $error("bad erase frame");

    property p_start_flags;
        @(posedge clock) disable iff (!rst_b)
            (start_block || start_array) |=> wip_q && !wel_q ##1 wip_q;
    endproperty
    a_start_flags: assert property (p_start_flags) else $error("busy or latch wrong at start");

    property p_no_protected_erase;
        @(posedge clock) disable iff (!rst_b)
            start_block |-> !block_is_protected(shift_q[23:16], protect_level_bits);
    endproperty
    a_no_protected_erase: assert property (p_no_protected_erase) else $error("protected erase");

    property p_array_frame;
        @(posedge clock) disable iff (!rst_b)
            start_array |-> bit_cnt_q == `SFE_OPCODE_BITS && protect_level_bits == 4'h0;
    endproperty
    a_array_frame: assert property (p_array_frame) else $error("bad array erase");

    property p_sleep_after_delay;
        @(posedge clock) disable iff (!rst_b)
            (pwr_q == sfe_pkg::PWR_ENTERING && wait_q == '0 && !op_ok) |=> sleep_q;
    endproperty
    a_sleep_after_delay: assert property (p_sleep_after_delay) else $error("sleep entry late");

    property p_sleep_ignores;
        @(posedge clock) disable iff (!rst_b) sleep_q |-> !(start_block || start_array);
    endproperty
    a_sleep_ignores: assert property (p_sleep_ignores) else $error("command taken asleep");

    property p_busy_keeps_standby;
        @(posedge clock) disable iff (!rst_b)
            (wip_q && pwr_q == sfe_pkg::PWR_STANDBY) |=> pwr_q == sfe_pkg::PWR_STANDBY;
    endproperty
    a_busy_keeps_standby: assert property (p_busy_keeps_standby) else $error("sleep during erase");

    property p_sleep_quiet;
        @(posedge clock) disable iff (!rst_b) sleep_q |-> !oe_q;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("output driven asleep");

    c_block: cover property (@(posedge clock) disable iff (!rst_b) start_block);
    c_array: cover property (@(posedge clock) disable iff (!rst_b) start_array);
    c_sleep: cover property (@(posedge clock) disable iff (!rst_b) $rose(sleep_q));
    c_id_out: cover property (@(posedge clock) disable iff (!rst_b) $rose(oe_q));
endmodule : sfe_flash_ctrl

// ### rtl/sfe_link_if.sv
// Purpose: synchronised pin events passed from the pin sampler to the core
// Assumes: all members are in the core clock domain
// Notes: pulses last one core clock
`timescale 1ns/1ns
interface sfe_link_if;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic cs_low;
    logic data_bit;
    modport src (output sclk_rise, sclk_fall, cs_rise, cs_fall, cs_low, data_bit);
    modport dst (input sclk_rise, sclk_fall, cs_rise, cs_fall, cs_low, data_bit);
endinterface : sfe_link_if

// ### rtl/sfe_map.svh
// Purpose: constants of the serial flash erase and power-down sequencer
// Assumes: a 100 MHz core clock sampling the serial pins
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// ----------------------------------------------------------------------
// opcodes and frame lengths
// ----------------------------------------------------------------------
`define SFE_OP_WRITE_UNLOCK 8'h06
`define SFE_OP_BLOCK_ERASE 8'hd8
`define SFE_OP_ARRAY_ERASE_A 8'hc7
`define SFE_OP_ARRAY_ERASE_B 8'h60
`define SFE_OP_DEEP_SLEEP 8'hb9
`define SFE_OP_WAKE_ID 8'hab
`define SFE_OPCODE_BITS 6'h08
`define SFE_ADDR_END_BITS 6'h20
`define SFE_BIT_CNT_MAX 6'h3f

// ----------------------------------------------------------------------
// address fields and protection
// ----------------------------------------------------------------------
`define SFE_BLOCK_MSB 23
`define SFE_BLOCK_LSB 16
`define SFE_PROTECT_NONE 4'h0
`define SFE_PROTECT_ALL 4'hf
`define SFE_ID_MSB_IDX 3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SFE_CLK_PERIOD_NS 10
`define SFE_CYC_PER_MS (1000000 / `SFE_CLK_PERIOD_NS)
`define SFE_BLOCK_ERASE_TIME_MS 200
`define SFE_ARRAY_ERASE_TIME_MS 45000
`define SFE_SLEEP_ENTRY_DELAY_NS 3000
`define SFE_WAKE_DELAY_PLAIN_NS 3000
`define SFE_WAKE_DELAY_WITH_ID_NS 1800
`define SFE_SLEEP_ENTRY_CYC (`SFE_SLEEP_ENTRY_DELAY_NS / `SFE_CLK_PERIOD_NS)
`define SFE_WAKE_PLAIN_CYC (`SFE_WAKE_DELAY_PLAIN_NS / `SFE_CLK_PERIOD_NS)
`define SFE_WAKE_WITH_ID_CYC (`SFE_WAKE_DELAY_WITH_ID_NS / `SFE_CLK_PERIOD_NS)
`define SFE_WAIT_W 12

`endif

// ### rtl/sfe_pin_sync.sv
// Purpose: two-flop synchronisers and edge finders for the serial pins
// Assumes: serial clock well below a quarter of the core clock
// Notes: edges are taken from the second and third stages
`timescale 1ns/1ns
`include "sfe_map.svh"
module sfe_pin_sync (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // raw pins
    input wire logic sclk_pin,
    input wire logic cs_b_pin,
    input wire logic serial_in_pin,
    // events to the core
    sfe_link_if.src link
);
    // bit 2 serial clock, bit 1 chip select (idles high), bit 0 data
    localparam logic [2:0] PIN_RST = 3'h2;

    logic [2:0] meta_q, meta_d;
    logic [2:0] sync_q, sync_d;
    logic [2:0] prev_q, prev_d;

    // ------------------------------------------------------------------
    // synchroniser chain
    // ------------------------------------------------------------------
    // first stage feeds only the second stage, never logic
    always_comb begin
        meta_d = {sclk_pin, cs_b_pin, serial_in_pin};
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= PIN_RST;
            sync_q <= PIN_RST;
            prev_q <= PIN_RST;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // edge events from stable stages
    assign link.sclk_rise = sync_q[2] & ~prev_q[2];
    assign link.sclk_fall = ~sync_q[2] & prev_q[2];
    assign link.cs_rise = sync_q[1] & ~prev_q[1];
    assign link.cs_fall = ~sync_q[1] & prev_q[1];
    assign link.cs_low = ~sync_q[1];
    assign link.data_bit = sync_q[0];
endmodule : sfe_pin_sync

// ### rtl/sfe_pkg.sv
// Purpose: types shared by the sequencer modules
// Assumes: nothing beyond the map header
// Notes: enums carry no explicit codes
package sfe_pkg;
    // power state of the device
    typedef enum logic [1:0] {PWR_STANDBY, PWR_ENTERING, PWR_ASLEEP, PWR_WAKING} sfe_pwr_t;
    // self-timed erase cycle
    typedef enum logic [1:0] {ERS_IDLE, ERS_BLOCK, ERS_ARRAY} sfe_erase_t;
endpackage : sfe_pkg
